//--- logic/mps_params.svh
// constants for the measurement power mode sequencer
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
// register indices; byte address is four times the index
`define MPS_IDX_STAT 8'hf3
`define MPS_IDX_CTRL 8'hf4
`define MPS_IDX_CFG 8'hf5
`define MPS_IDX_PRESS 8'hf7
`define MPS_IDX_TEMP 8'hfa
// reset values
`define MPS_CTRL_RST 8'h00
`define MPS_CFG_RST 8'h00
// mode field patterns
`define MPS_MODE_SLEEP 2'h0
`define MPS_MODE_FORCED 2'h1
`define MPS_MODE_NORMAL 2'h3
// oversampling and filter codes
`define MPS_OSRS_SKIP 3'h0
`define MPS_OSRS_MAX 3'h5
`define MPS_FILT_MAX 3'h4
`define MPS_SKIP_VAL 20'h80000
// timing, in ns, and the clock period
`define MPS_CLK_NS 100
`define MPS_STEP_NS 200000
`define MPS_STBY0_NS 500000
`define MPS_STBY1_NS 62500000
// bus answers
`define MPS_RESP_OKAY 2'h0
`define MPS_RESP_SLVERR 2'h2
`endif

//--- logic/mps_pkg.sv
// types shared by the measurement power mode sequencer
`default_nettype none
package mps_pkg;
  typedef enum logic [1:0] {MD_SLEEP, MD_FORCED, MD_NORMAL} mps_run_mode_t;
  typedef enum logic [1:0] {ST_SLEEP, ST_TEMP, ST_PRESS, ST_STBY} mps_seq_t;
  typedef struct packed {
    logic [2:0] osrs_t;
    logic [2:0] osrs_p;
    logic [1:0] mode;
  } mps_ctrl_t;
  typedef struct packed {
    logic [2:0] standby_time_select;
    logic [2:0] filter;
    logic [1:0] spare;
  } mps_cfg_t;
endpackage : mps_pkg
`default_nettype wire

//--- logic/mps_sequencer.sv
// measurement power mode sequencer with axi4-lite register slave
`include "mps_params.svh"
`default_nettype none
module mps_sequencer #(
  parameter int unsigned STBY0_CYC = `MPS_STBY0_NS / `MPS_CLK_NS,
  parameter int unsigned STBY1_CYC = `MPS_STBY1_NS / `MPS_CLK_NS,
  parameter int unsigned STEP_CYC = `MPS_STEP_NS / `MPS_CLK_NS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // axi4-lite write channels
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter results and status
  input wire logic [19:0] adc_temp_raw,
  input wire logic [19:0] adc_press_raw,
  output logic measuring
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  mps_pkg::mps_seq_t state_q, state_d;
  mps_pkg::mps_run_mode_t mode_q, mode_d, pend_mode_q, pend_mode_d;
  mps_pkg::mps_run_mode_t wr_mode, req_mode, end_mode;
  mps_pkg::mps_ctrl_t ctrl_q, ctrl_d;
  mps_pkg::mps_cfg_t cfg_q, cfg_d;
  logic pend_q, pend_d, req_go;
  logic [31:0] timer_q, timer_d;
  logic [19:0] raw_t_q, raw_t_d;
  logic [19:0] mem_q [2], mem_d [2], out_q [2], out_d [2], filt_new [2];
  logic [19:0] raw_sel [2];
  logic [1:0] finit_q, finit_d;
  logic [2:0] osrs_sel [2];
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go, rd_go, wr_ctrl, wr_cfg, meas_end;
  logic [7:0] wr_idx, rd_idx;

  // phase length from an oversampling code; skip gives zero
  function automatic logic [31:0] phase_len(input logic [2:0] osrs);
    logic [2:0] c;
    c = (osrs > `MPS_OSRS_MAX) ? `MPS_OSRS_MAX : osrs;
    phase_len = (osrs == `MPS_OSRS_SKIP) ? 32'h0 : STEP_CYC << (c - 3'h1);
  endfunction : phase_len

  // standby count: code 0 is 0.5 ms, code n doubles from 62.5 ms
  function automatic logic [31:0] stby_len(input logic [2:0] sel);
    stby_len = (sel == 3'h0) ? STBY0_CYC : STBY1_CYC << (sel - 3'h1);
  endfunction : stby_len

  // mode pattern decode; both middle patterns mean forced
  function automatic mps_pkg::mps_run_mode_t dec(input logic [1:0] m);
    case (m)
      `MPS_MODE_SLEEP: dec = mps_pkg::MD_SLEEP;
      `MPS_MODE_NORMAL: dec = mps_pkg::MD_NORMAL;
      default: dec = mps_pkg::MD_FORCED;
    endcase
  endfunction : dec

  // ------------------------------------------------------------------
  // smoothing filter, one lane per channel (0 temp, 1 press)
  // ------------------------------------------------------------------
  assign raw_sel[0] = raw_t_q;
  assign raw_sel[1] = adc_press_raw;
  assign osrs_sel[0] = ctrl_q.osrs_t;
  assign osrs_sel[1] = ctrl_q.osrs_p;
  for (genvar ch = 0; ch < 2; ch++) begin : g_filt
    logic [20:0] diff, step;
    logic [2:0] k;
    // shift form of old*(c-1)/c + new/c; truncation loses low bits
    assign k = (cfg_q.filter > `MPS_FILT_MAX) ? `MPS_FILT_MAX : cfg_q.filter;
    assign diff = {1'b0, raw_sel[ch]} - {1'b0, mem_q[ch]};
    assign step = $signed(diff) >>> k;
    assign filt_new[ch] = finit_q[ch] ? raw_sel[ch] :
                          20'(mem_q[ch] + step[19:0]);
  end

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rd_go = s_axi_arvalid & ~rvalid_q;
  assign wr_idx = s_axi_awaddr[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_ctrl = wr_go & s_axi_wstrb[0] & (wr_idx == `MPS_IDX_CTRL);
  assign wr_cfg = wr_go & s_axi_wstrb[0] & (wr_idx == `MPS_IDX_CFG);
  assign wr_mode = dec(s_axi_wdata[1:0]);
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign measuring = (state_q == mps_pkg::ST_TEMP) ||
                     (state_q == mps_pkg::ST_PRESS);
  assign meas_end = (state_q == mps_pkg::ST_PRESS) && (timer_q == 32'h0);
  // pending change is served first; otherwise a fresh write when idle
  assign req_go = pend_q | (wr_ctrl & ~measuring);
  assign req_mode = pend_q ? pend_mode_q : wr_mode;
  // forced falls back to sleep unless a change was held back
  assign end_mode = pend_q ? pend_mode_q :
                    (mode_q == mps_pkg::MD_FORCED) ? mps_pkg::MD_SLEEP :
                    mode_q;

  // ------------------------------------------------------------------
  // sequencer and register next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    pend_d = pend_q;
    pend_mode_d = pend_mode_q;
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    timer_d = (timer_q == 32'h0) ? timer_q : timer_q - 32'h1;
    raw_t_d = raw_t_q;
    mem_d = mem_q;
    out_d = out_q;
    finit_d = finit_q;
    // settings other than mode take effect at once
    if (wr_ctrl) begin
      ctrl_d.osrs_t = s_axi_wdata[7:5];
      ctrl_d.osrs_p = s_axi_wdata[4:2];
    end
    case (state_q)
      mps_pkg::ST_SLEEP: begin
        pend_d = 1'b0;
        if (req_go) begin
          mode_d = req_mode;
          if (req_mode != mps_pkg::MD_SLEEP) begin
            state_d = mps_pkg::ST_TEMP;
            timer_d = phase_len(ctrl_d.osrs_t);
          end
        end
      end
      mps_pkg::ST_TEMP: begin
        if (timer_q == 32'h0) begin
          raw_t_d = adc_temp_raw;
          state_d = mps_pkg::ST_PRESS;
          timer_d = phase_len(ctrl_q.osrs_p);
        end
      end
      mps_pkg::ST_PRESS: begin
        if (timer_q == 32'h0) begin
          for (int ch = 0; ch < 2; ch++) begin
            if (osrs_sel[ch] == `MPS_OSRS_SKIP) begin
              out_d[ch] = `MPS_SKIP_VAL;
            end else begin
              out_d[ch] = filt_new[ch];
              mem_d[ch] = filt_new[ch];
              finit_d[ch] = 1'b0;
            end
          end
          pend_d = 1'b0;
          mode_d = end_mode;
          if (end_mode == mps_pkg::MD_NORMAL) begin
            state_d = mps_pkg::ST_STBY;
            timer_d = stby_len(cfg_q.standby_time_select);
          end else if (end_mode == mps_pkg::MD_FORCED) begin
            state_d = mps_pkg::ST_TEMP;
            timer_d = phase_len(ctrl_q.osrs_t);
          end else begin
            state_d = mps_pkg::ST_SLEEP;
          end
        end
      end
      mps_pkg::ST_STBY: begin
        pend_d = 1'b0;
        if (timer_q == 32'h0) begin
          state_d = mps_pkg::ST_TEMP;
          timer_d = phase_len(ctrl_d.osrs_t);
        end
        if (req_go) begin
          mode_d = req_mode;
          if (req_mode == mps_pkg::MD_SLEEP) begin
            state_d = mps_pkg::ST_SLEEP;
          end else if (req_mode == mps_pkg::MD_FORCED) begin
            state_d = mps_pkg::ST_TEMP;
            timer_d = phase_len(ctrl_d.osrs_t);
          end
        end
      end
      default: begin
        state_d = mps_pkg::ST_SLEEP;
      end
    endcase
    // a mode write mid-measurement is held; later ones are dropped
    if (wr_ctrl && measuring && !pend_q) begin
      pend_d = 1'b1;
      pend_mode_d = wr_mode;
    end
    // written last so a reload request beats a same-cycle update
    if (wr_cfg) begin
      cfg_d.standby_time_select = s_axi_wdata[7:5];
      cfg_d.filter = s_axi_wdata[4:2];
      finit_d = 2'h3;
    end
  end

  // bus answers, one cycle after acceptance
  always_comb begin
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = (wr_idx == `MPS_IDX_CTRL || wr_idx == `MPS_IDX_CFG ||
                 wr_idx == `MPS_IDX_STAT || wr_idx == `MPS_IDX_PRESS ||
                 wr_idx == `MPS_IDX_TEMP) ? `MPS_RESP_OKAY : `MPS_RESP_SLVERR;
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = `MPS_RESP_OKAY;
      case (rd_idx)
        `MPS_IDX_CTRL: rdata_d = {24'h0, ctrl_q.osrs_t, ctrl_q.osrs_p,
          (mode_q == mps_pkg::MD_SLEEP) ? `MPS_MODE_SLEEP :
          (mode_q == mps_pkg::MD_FORCED) ? `MPS_MODE_FORCED :
          `MPS_MODE_NORMAL};
        `MPS_IDX_CFG: rdata_d = {24'h0, cfg_q};
        `MPS_IDX_STAT: rdata_d = {28'h0, measuring, 2'h0, pend_q};
        `MPS_IDX_PRESS: rdata_d = {12'h0, out_q[1]};
        `MPS_IDX_TEMP: rdata_d = {12'h0, out_q[0]};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `MPS_RESP_SLVERR;
        end
      endcase
    end
  end

  // registers; reset lands in sleep with nothing written
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= mps_pkg::ST_SLEEP;
      mode_q <= mps_pkg::MD_SLEEP;
      pend_q <= 1'b0;
      pend_mode_q <= mps_pkg::MD_SLEEP;
      ctrl_q <= `MPS_CTRL_RST;
      cfg_q <= `MPS_CFG_RST;
      timer_q <= 32'h0;
      raw_t_q <= 20'h0;
      mem_q <= '{default: 20'h0};
      out_q <= '{default: `MPS_SKIP_VAL};
      finit_q <= 2'h3;
      bvalid_q <= 1'b0;
      bresp_q <= `MPS_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `MPS_RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      pend_q <= pend_d;
      pend_mode_q <= pend_mode_d;
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      timer_q <= timer_d;
      raw_t_q <= raw_t_d;
      mem_q <= mem_d;
      out_q <= out_d;
      finit_q <= finit_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_RESET_SLEEP: assert property ($past(!rst_b) |->
    mode_q == mps_pkg::MD_SLEEP && !measuring) else $error("not asleep");
  AST_SLEEP_IDLE: assert property (state_q == mps_pkg::ST_SLEEP &&
    !wr_ctrl && !pend_q |=> !measuring) else $error("sleep measured");
  AST_DECODE_NORMAL: assert property (wr_ctrl && !measuring && !pend_q &&
    s_axi_wdata[1:0] == `MPS_MODE_NORMAL |=> mode_q == mps_pkg::MD_NORMAL)
    else $error("normal not decoded");
  AST_FORCED_BACK: assert property (meas_end && !pend_q && !wr_ctrl &&
    mode_q == mps_pkg::MD_FORCED |=> state_q == mps_pkg::ST_SLEEP ##1
    (state_q == mps_pkg::ST_SLEEP || $past(wr_ctrl))) else $error("rerun");
  AST_STBY_LOAD: assert property (meas_end && !wr_cfg &&
    end_mode == mps_pkg::MD_NORMAL |=> state_q == mps_pkg::ST_STBY &&
    timer_q == stby_len(cfg_q.standby_time_select)) else $error("standby");
  AST_DEFER: assert property (measuring && !meas_end |=>
    $stable(mode_q)) else $error("mode changed mid measurement");
  AST_IGNORE: assert property (pend_q && measuring && wr_ctrl |=>
    pend_mode_q == $past(pend_mode_q)) else $error("pending overwritten");
  AST_SKIP: assert property (meas_end &&
    ctrl_q.osrs_t == `MPS_OSRS_SKIP |=> out_q[0] == `MPS_SKIP_VAL &&
    $stable(mem_q[0])) else $error("skip value wrong");
  AST_FILT_RELOAD: assert property (wr_cfg |=> finit_q == 2'h3)
    else $error("filter not reset");
  COV_FORCED: cover property (mode_q == mps_pkg::MD_FORCED && meas_end);
  COV_NORMAL: cover property (meas_end && end_mode == mps_pkg::MD_NORMAL);
  COV_PEND: cover property (pend_q && wr_ctrl && measuring);
endmodule : mps_sequencer
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the measurement power mode sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------
  // shortened counts, addresses and bench state
  // ---------------------------------------------
  localparam int unsigned STEP = 4;
  localparam int unsigned SB0 = 8;
  localparam int unsigned SB1 = 16;
  localparam logic [9:0] A_STAT = 10'h3cc;
  localparam logic [9:0] A_CTRL = 10'h3d0;
  localparam logic [9:0] A_CFG = 10'h3d4;
  localparam logic [9:0] A_PRESS = 10'h3dc;
  localparam logic [9:0] A_TEMP = 10'h3e8;
  logic sys_clk, rst_b, measuring;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [19:0] adc_temp_raw, adc_press_raw;
  int n_mismatch, checks, c;
  logic [31:0] d;
  logic [1:0] r;
  mps_sequencer #(.STBY0_CYC(SB0), .STBY1_CYC(SB1), .STEP_CYC(STEP)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .adc_temp_raw(adc_temp_raw),
    .adc_press_raw(adc_press_raw), .measuring(measuring));
  // free-running system clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------
  // shared helpers
  // ---------------------------------------------
  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one edge; a wait that runs too long ends the run
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 400) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : tick
  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] v);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      tick(n);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do tick(n); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [9:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    axi_rd(a);
    check(d, exp);
  endtask : rd_chk
  // edges until measuring is seen at lvl
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    do tick(n); while (measuring !== lvl);
  endtask : wait_lvl
  // true when measuring never rises over n edges
  task automatic quiet(input int n);
    int k;
    logic hi;
    k = 0;
    hi = 1'b0;
    repeat (n) begin
      tick(k);
      hi = hi | measuring;
    end
    check(hi, 1'b0);
  endtask : quiet
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    check(measuring, 1'b0);
    rd_chk(A_CTRL, 32'h0000_0000);
    rd_chk(A_PRESS, 32'h0008_0000);
    rd_chk(10'h040, 32'h0000_0000);
    check(r, `MPS_RESP_SLVERR);
    axi_wr(10'h044, 32'h0000_0011);
    check(r, `MPS_RESP_SLVERR);
    axi_wr(A_PRESS, 32'h0001_2345);
    check(r, `MPS_RESP_OKAY);
    rd_chk(A_PRESS, 32'h0008_0000);
    axi_wr(A_CTRL, 32'h0000_0024);
    quiet(30);
  endtask : t_reset
  task automatic t_forced;
    // both forced patterns, one measurement each
    for (int p = 1; p <= 2; p++) begin
      adc_press_raw <= 20'h12340 + 20'(p);
      adc_temp_raw <= 20'h56780 + 20'(p);
      axi_wr(A_CTRL, 32'h48 | 32'(p));
      rd_chk(A_CTRL, 32'h0000_0049);
      wait_lvl(1'b0, c);
      rd_chk(A_CTRL, 32'h0000_0048);
      rd_chk(A_PRESS, 32'h12340 + 32'(p));
      rd_chk(A_TEMP, 32'h56780 + 32'(p));
      quiet(40);
    end
    // skipped temperature conversion
    axi_wr(A_CTRL, 32'h0000_0005);
    wait_lvl(1'b0, c);
    rd_chk(A_TEMP, 32'h0008_0000);
    rd_chk(A_PRESS, 32'h0001_2342);
    // filter rewrite lets the next sample straight through
    axi_wr(A_CFG, 32'h0000_0004);
    adc_press_raw <= 20'h0a5a5;
    axi_wr(A_CTRL, 32'h0000_0025);
    wait_lvl(1'b0, c);
    rd_chk(A_PRESS, 32'h0000_a5a5);
  endtask : t_forced
  task automatic t_normal;
    axi_wr(A_CFG, 32'h0000_0000);
    axi_wr(A_CTRL, 32'h0000_0027);
    rd_chk(A_CTRL, 32'h0000_0027);
    wait_lvl(1'b0, c);
    wait_lvl(1'b1, c);
    check(c, SB0 + 1);
    wait_lvl(1'b0, c);
    check(c, (STEP + 1) * 2);
    adc_press_raw <= 20'h3c3c3;
    wait_lvl(1'b1, c);
    wait_lvl(1'b0, c);
    rd_chk(A_PRESS, 32'h0003_c3c3);
    // filtered normal run: coefficient two averages old and new
    axi_wr(A_CFG, 32'h0000_0004);
    wait_lvl(1'b1, c);
    wait_lvl(1'b0, c);
    adc_press_raw <= 20'h3c4c3;
    wait_lvl(1'b1, c);
    wait_lvl(1'b0, c);
    rd_chk(A_PRESS, 32'h0003_c443);
    // longer standby codes double from the first long step
    for (int k = 1; k <= 4; k++) begin
      axi_wr(A_CFG, 32'(k) << 5);
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, c);
      wait_lvl(1'b1, c);
      check(c, (SB1 << (k - 1)) + 1);
    end
  endtask : t_normal
  task automatic t_defer;
    axi_wr(A_CFG, 32'h0000_0000);
    wait_lvl(1'b0, c);
    axi_wr(A_CTRL, 32'h0000_006f);
    wait_lvl(1'b1, c);
    // sleep request parks until the measurement ends
    axi_wr(A_CTRL, 32'h0000_006c);
    rd_chk(A_STAT, 32'h0000_0009);
    rd_chk(A_CTRL, 32'h0000_006f);
    axi_wr(A_CTRL, 32'h0000_006d);
    wait_lvl(1'b0, c);
    rd_chk(A_CTRL, 32'h0000_006c);
    quiet(60);
  endtask : t_defer
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_b = 1'b0;
    s_axi_awaddr = 10'h000;
    s_axi_araddr = 10'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    adc_temp_raw = 20'h00000;
    adc_press_raw = 20'h00000;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_forced();
    t_normal();
    t_defer();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
